/* File: common/sci_brk_regs.svh */
// Register offsets, field positions and timing counts for the break and status block
// Notes on behaviour
// - Receive polarity invert flips the receive line before any receiver processing.
// - Long break clear: transmitted break lasts 10 bit times, 11 in nine-bit format.
// - Long break set: transmitted break lasts 13 bit times, 14 in nine-bit format.
// - Framing error detection ignores the long break select bit entirely.
// - LIN break detect enable blocks framing error and receive full from setting.
// - Detect enable clear: break seen after 10 low bit times, 11 in nine-bit.
// - Detect enable set: break seen after 11 low bit times, 12 in nine-bit.
// - Receiver active flag sets when the receive line goes low.
// - Receiver active flag clears by itself when the line goes idle.
// - Nine-bit format select gives nine data bits per character.
// - Detected LIN break sets the LIN break flag; writing one clears it.
`ifndef SCI_BRK_REGS_SVH
`define SCI_BRK_REGS_SVH
`define OFS_STATUS_TWO   8'h00
`define OFS_CONTROL      8'h04
`define OFS_BREAK_CMD    8'h08
`define OFS_FLAGS        8'h0c
`define BIT_LIN_FLAG     7
`define BIT_RX_INV       4
`define BIT_WAKE_IDLE    3
`define BIT_LONG_BREAK   2
`define BIT_LIN_ENABLE   1
`define BIT_RX_ACTIVE    0
`define BIT_NINE_BIT     0
`define BIT_TX_INV       1
`define BIT_FRAME_ERR    0
`define BIT_RX_FULL      1
`define BIT_BREAK_BUSY   2
`define BIT_BREAK_GO     0
`define BRK_TX_SHORT     5'd10
`define BRK_TX_LONG      5'd13
`define BRK_RX_SHORT     5'd10
`define BRK_RX_LIN       5'd11
`define FRAME_BITS8      5'd10
`define IDLE_BITS        5'd10
`define BAUD_DIV_DEF     16
`endif

/* File: common/sci_brk_pkg.sv */
// Types shared by the break and status block
package sci_brk_pkg;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_FRAME = 3'b010,
    RX_BREAK = 3'b100
  } rx_state_t;
  typedef struct packed {
    logic nine_bit;
    logic tx_invert;
    logic rx_invert;
    logic wake_idle;
    logic long_break;
    logic lin_enable;
  } ctrl_t;
endpackage : sci_brk_pkg

/* File: hdl/sci_brk_status.sv */
// Break generation, break detection and receiver activity with AXI4-Lite registers
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sci_brk_regs.svh"
module sci_brk_status
  import sci_brk_pkg::*;
#(
  parameter int BAUD_DIV = `BAUD_DIV_DEF
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line
  input  wire logic        rxd,
  output logic             txd
);
  localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);
  // First count ends half a bit into the start bit, so every later sample falls mid bit
  localparam logic [15:0] START_OFS = 16'(BAUD_DIV - BAUD_DIV / 2);

  ctrl_t       ctrl;
  rx_state_t   rx_state;
  logic [2:0]  rx_sync;
  logic        rx_line;
  logic [15:0] rx_div;
  logic [4:0]  rx_bits;
  logic [4:0]  low_bits;
  logic [4:0]  idle_bits;
  logic        rx_active;
  logic        lin_flag;
  logic        frame_err;
  logic        rx_full;
  logic [15:0] tx_div;
  logic [4:0]  tx_left;
  logic        brk_req;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        break_hit;
  logic        frame_end;
  logic [4:0]  brk_rx_len;
  logic [4:0]  frame_len;

  assign do_write   = aw_held && w_held && !s_axi_bvalid;
  assign brk_rx_len = (ctrl.lin_enable ? `BRK_RX_LIN : `BRK_RX_SHORT) + {4'h0, ctrl.nine_bit};
  assign frame_len  = `FRAME_BITS8 + {4'h0, ctrl.nine_bit};
  assign break_hit  = rx_div == DIV_LAST && !rx_line && low_bits + 5'd1 >= brk_rx_len;
  assign frame_end  = rx_state == RX_FRAME && rx_div == DIV_LAST && rx_bits + 5'd1 == frame_len;

  // Three-stage pin synchroniser; inversion after agreement of stages two and three
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_sync <= 3'b111;
      rx_line <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rxd};
      if (rx_sync[1] == rx_sync[2])
        rx_line <= rx_sync[2] ^ ctrl.rx_invert;
    end
  end

  // Receiver sequencing and low/idle bit counting
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_state  <= RX_IDLE;
      rx_div    <= 16'h0000;
      rx_bits   <= 5'd0;
      low_bits  <= 5'd0;
      idle_bits <= 5'd0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_div    <= START_OFS;
          rx_bits   <= 5'd0;
          low_bits  <= 5'd0;
          idle_bits <= 5'd0;
          if (!rx_line)
            rx_state <= RX_FRAME;
        end
        RX_FRAME, RX_BREAK: begin
          rx_div <= (rx_div == DIV_LAST) ? 16'h0000 : rx_div + 16'h0001;
          if (rx_div == DIV_LAST) begin
            rx_bits   <= (rx_bits == 5'h1f) ? rx_bits : rx_bits + 5'd1;
            low_bits  <= rx_line ? 5'd0 : ((low_bits == 5'h1f) ? low_bits : low_bits + 5'd1);
            idle_bits <= !rx_line ? 5'd0 : idle_bits + 5'd1;
            if (break_hit)
              rx_state <= RX_BREAK;
            if (rx_line && (rx_state == RX_BREAK || rx_bits + 5'd1 >= frame_len)) begin
              if (idle_bits + 5'd1 >= `IDLE_BITS || rx_state == RX_BREAK)
                rx_state <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Receiver active flag: follows the receiver sequencing, read only
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      rx_active <= 1'b0;
    else
      rx_active <= (rx_state != RX_IDLE) || !rx_line;
  end

  // Status flags; a set in the same cycle as a write-one clear wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lin_flag  <= 1'b0;
      frame_err <= 1'b0;
      rx_full   <= 1'b0;
    end else begin
      if (do_write && aw_addr == `OFS_STATUS_TWO && w_strb[0] && w_data[`BIT_LIN_FLAG])
        lin_flag <= 1'b0;
      if (do_write && aw_addr == `OFS_FLAGS && w_strb[0] && w_data[`BIT_FRAME_ERR])
        frame_err <= 1'b0;
      if (do_write && aw_addr == `OFS_FLAGS && w_strb[0] && w_data[`BIT_RX_FULL])
        rx_full <= 1'b0;
      if (break_hit && rx_state == RX_FRAME && ctrl.lin_enable)
        lin_flag <= 1'b1;
      // Stop bit check independent of long break select
      if (frame_end && !ctrl.lin_enable) begin
        rx_full <= 1'b1;
        if (!rx_line)
          frame_err <= 1'b1;
      end
    end
  end

  // Control register writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == `OFS_STATUS_TWO) begin
        ctrl.rx_invert  <= w_data[`BIT_RX_INV];
        ctrl.wake_idle  <= w_data[`BIT_WAKE_IDLE];
        ctrl.long_break <= w_data[`BIT_LONG_BREAK];
        ctrl.lin_enable <= w_data[`BIT_LIN_ENABLE];
      end else if (aw_addr == `OFS_CONTROL) begin
        ctrl.nine_bit  <= w_data[`BIT_NINE_BIT];
        ctrl.tx_invert <= w_data[`BIT_TX_INV];
      end
    end
  end

  // Break transmitter: space for the selected length, then mark
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_left <= 5'd0;
      tx_div  <= 16'h0000;
      brk_req <= 1'b0;
      txd     <= 1'b1;
    end else begin
      brk_req <= do_write && aw_addr == `OFS_BREAK_CMD && w_strb[0] && w_data[`BIT_BREAK_GO] && tx_left == 5'd0;
      if (brk_req) begin
        tx_left <= (ctrl.long_break ? `BRK_TX_LONG : `BRK_TX_SHORT) + {4'h0, ctrl.nine_bit};
        tx_div  <= 16'h0000;
      end else if (tx_left != 5'd0) begin
        tx_div <= (tx_div == DIV_LAST) ? 16'h0000 : tx_div + 16'h0001;
        if (tx_div == DIV_LAST)
          tx_left <= tx_left - 5'd1;
      end
      // Space only while the counter runs, so the break is exactly len bit times
      txd <= ((tx_left != 5'd0) ? 1'b0 : 1'b1) ^ ctrl.tx_invert;
    end
  end

  // AXI write channel: address and data taken in either order
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[7:4] == 4'h0 && aw_addr[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read channel; unmapped addresses answer SLVERR with zero data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `OFS_STATUS_TWO: s_axi_rdata <= {24'h0, lin_flag, 2'b00, ctrl.rx_invert, ctrl.wake_idle,
                                           ctrl.long_break, ctrl.lin_enable, rx_active};
          `OFS_CONTROL:    s_axi_rdata <= {30'h0, ctrl.tx_invert, ctrl.nine_bit};
          `OFS_BREAK_CMD:  s_axi_rdata <= 32'h0000_0000;
          `OFS_FLAGS:      s_axi_rdata <= {29'h0, tx_left != 5'd0, rx_full, frame_err};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence brk_start_s;
    brk_req && !ctrl.long_break && !ctrl.nine_bit;
  endsequence
  tx_break_space_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    brk_req |=> ##1 (txd == ctrl.tx_invert)) else $error("break not at space");
  tx_short_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    brk_start_s |=> tx_left == `BRK_TX_SHORT) else $error("short break length wrong");
  tx_long_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    brk_req && ctrl.long_break |=> tx_left == `BRK_TX_LONG + {4'h0, $past(ctrl.nine_bit)})
    else $error("long break length wrong");
  lin_blocks_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl.lin_enable && !rx_full && !frame_err |=> !rx_full && !frame_err)
    else $error("receive flag set under LIN");
  lin_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    break_hit && rx_state == RX_FRAME && ctrl.lin_enable |=> lin_flag) else $error("LIN flag missed");
  rx_break_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_state == RX_FRAME ##1 rx_state == RX_BREAK |->
      low_bits == (($past(ctrl.lin_enable) ? `BRK_RX_LIN : `BRK_RX_SHORT) + {4'h0, $past(ctrl.nine_bit)}))
    else $error("break length wrong");
  rx_active_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_state == RX_IDLE && !rx_line |=> rx_active) else $error("receiver active not set");
  rx_active_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_state == RX_IDLE && rx_line ##1 rx_line |-> ##1 !rx_active) else $error("receiver active stuck");
endmodule : sci_brk_status

/* File: tb/sci_line_node.sv */
// Remote serial node: drives the receive line and times breaks seen on txd
`timescale 1ns/1ps
module sci_line_node #(
  parameter int BAUD_DIV = 4
) (
  // Clock
  input  wire logic sys_clk,
  // Serial line
  input  wire logic txd,
  output logic      rxd,
  output int        low_len
);
  int run;
  // Line pulled up to mark between frames
  initial begin
    rxd = 1'b1;
    low_len = 0;
    run = 0;
  end
  // Length of the last space run on txd, in clocks
  always @(posedge sys_clk) begin
    if (!txd) run <= run + 1;
    else begin
      if (run != 0) low_len <= run;
      run <= 0;
    end
  end
  // Send n bits lsb first, then idle; inv mimics a node of opposite polarity
  task automatic send(input logic [15:0] v, input int n, input logic inv);
    for (int i = 0; i < n; i++) begin
      rxd <= v[i] ^ inv;
      repeat (BAUD_DIV) @(posedge sys_clk);
    end
    rxd <= ~inv;
  endtask : send
endmodule : sci_line_node

/* File: tb/sci_brk_status_tb_top.sv */
// Self-checking bench for the break and status block
`timescale 1ns/1ps
`include "sci_brk_regs.svh"
module sci_brk_status_tb_top;
  import sci_brk_pkg::*;
  localparam int DIV = 4;
  logic        sys_clk, rst_n, rxd, txd;
  logic [7:0]  awaddr, araddr, byte_v;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          low_len, n_fail, n_checks;

  sci_brk_status #(.BAUD_DIV(DIV)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rxd(rxd), .txd(txd));
  sci_line_node #(.BAUD_DIV(DIV)) node (.sys_clk(sys_clk), .txd(txd), .rxd(rxd), .low_len(low_len));

  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: reg %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_len(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: break len %0d exp %0d", $time, got, exp);
    end
  endtask : chk_len

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (awready && !aw_ok) begin
        awvalid <= 0;
        aw_ok = 1;
      end
      if (wready && !w_ok) begin
        wvalid <= 0;
        w_ok = 1;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    rsp = bresp;
    bready <= 0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 0;
    do @(posedge sys_clk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a, d, rsp);
    chk_reg(d & m, e);
  endtask : rd_chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Watchdog well beyond the thousand-odd cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    complete_run;
  end

  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'h029a));
    byte_v = 8'($urandom()) | 8'h01;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    rd_chk(`OFS_STATUS_TWO, 32'hff, 0);
    axi_rd(8'h10, d, rsp);
    chk_reg({30'h0, rsp}, 32'h2);
    chk_reg(d, 0);
    axi_wr(8'h10, 32'hff);
    chk_reg({30'h0, rsp}, 32'h2);
    // Break length for each format and length choice
    for (int k = 0; k < 4; k++) begin
      axi_wr(`OFS_CONTROL, k & 1);
      axi_wr(`OFS_STATUS_TWO, (k >> 1) << `BIT_LONG_BREAK);
      axi_wr(`OFS_BREAK_CMD, 1);
      chk_reg({30'h0, rsp}, 0);
      repeat (20 * DIV) @(posedge sys_clk);
      chk_len(low_len, ((k[1] ? 13 : 10) + k[0]) * DIV);
    end
    axi_wr(`OFS_CONTROL, 0);
    axi_wr(`OFS_STATUS_TWO, 0);
    // Good frame: active flag mid-frame, idle after, data flagged
    fork
      node.send({1'b1, byte_v, 1'b0}, 10, 0);
      begin
        repeat (3 * DIV) @(posedge sys_clk);
        rd_chk(`OFS_STATUS_TWO, 1, 1);
      end
    join
    repeat (13 * DIV) @(posedge sys_clk);
    rd_chk(`OFS_STATUS_TWO, 1, 0);
    rd_chk(`OFS_FLAGS, 3, 2);
    axi_wr(`OFS_FLAGS, 3);
    // Low stop bit is a framing error whatever the break length
    for (int lb = 0; lb < 2; lb++) begin
      axi_wr(`OFS_STATUS_TWO, lb << `BIT_LONG_BREAK);
      node.send({1'b0, byte_v, 1'b0}, 10, 0);
      repeat (13 * DIV) @(posedge sys_clk);
      rd_chk(`OFS_FLAGS, 1, 1);
      axi_wr(`OFS_FLAGS, 3);
    end
    // Detect enable: flags held off, a ten-bit low run is no break
    axi_wr(`OFS_STATUS_TWO, 2);
    node.send({1'b0, byte_v, 1'b0}, 10, 0);
    repeat (13 * DIV) @(posedge sys_clk);
    node.send(0, 10, 0);
    repeat (13 * DIV) @(posedge sys_clk);
    rd_chk(`OFS_FLAGS, 3, 0);
    rd_chk(`OFS_STATUS_TWO, 32'h80, 0);
    node.send(0, 12, 0);
    repeat (4 * DIV) @(posedge sys_clk);
    rd_chk(`OFS_STATUS_TWO, 32'h80, 32'h80);
    axi_wr(`OFS_STATUS_TWO, 32'h82);
    rd_chk(`OFS_STATUS_TWO, 32'h80, 0);
    // Inverted receive line: a high run reads as a break
    node.send(0, 0, 1);
    axi_wr(`OFS_STATUS_TWO, 32'h12);
    repeat (13 * DIV) @(posedge sys_clk);
    axi_wr(`OFS_STATUS_TWO, 32'h92);
    node.send(0, 12, 1);
    repeat (4 * DIV) @(posedge sys_clk);
    rd_chk(`OFS_STATUS_TWO, 32'h80, 32'h80);
    complete_run;
  end
endmodule : sci_brk_status_tb_top
